/* ocl_map.svh */
`ifndef OCL_MAP_SVH
`define OCL_MAP_SVH

// Register indices; byte address is four times the index
`define OCL_IDX_CFG 8'hc7
`define OCL_IDX_UPPER 8'hc8
`define OCL_IDX_LOWER 8'hc9
`define OCL_IDX_SPARE_A 8'hca
`define OCL_IDX_SPARE_B 8'hcb
`define OCL_IDX_SPARE_C 8'hcc
`define OCL_IDX_IRQ_STAT 8'hd8
`define OCL_IDX_IRQ_MASK 8'hd9

// Reset values
`define OCL_RST_CFG 16'h0000
`define OCL_RST_UPPER 16'h7fff
`define OCL_RST_LOWER 16'h8000
`define OCL_RST_SPARE_A 16'h5555
`define OCL_RST_SPARE_B 16'h0010
`define OCL_RST_SPARE_C 16'h0000

// Writable bit masks
`define OCL_MASK_CFG 16'hff00
`define OCL_MASK_SPARE_B 16'h07f0
`define OCL_MASK_SPARE_C 16'hc703

// Field positions
`define OCL_CFG_LSB 8
`define OCL_IRQ_UPPER_BIT 0
`define OCL_IRQ_LOWER_BIT 1

// Limit codes that switch a side off
`define OCL_UPPER_OFF 16'h7fff
`define OCL_LOWER_OFF 16'h8000

`endif

/* ocl_pkg.sv */
package ocl_pkg;

   typedef struct packed {
      logic enable;
      logic polarity;
      logic spare;
      logic [4:0] num;
   } ocl_cfg_t;

   typedef struct packed {
      logic lower;
      logic upper;
   } ocl_trip_t;

endpackage

/* ocl_trip_filter.sv */
`timescale 1ns/1ps
`default_nettype none

module ocl_trip_filter #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sample path
   input wire logic enable,
   input wire logic sample_valid,
   input wire logic exceed,
   input wire logic [CNT_W-1:0] need,
   // Result
   output logic trip_event
);

   logic [CNT_W-1:0] run;
   logic [CNT_W-1:0] next_run;

   // Saturates at need so the run never wraps
   always_comb begin
      next_run = (run >= need) ? run : run + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= '0;
      end else if (!enable) begin
         run <= '0;
      end else if (sample_valid) begin
         run <= exceed ? next_run : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_event <= 1'b0;
      end else if (!enable) begin
         trip_event <= 1'b0;
      end else if (sample_valid) begin
         trip_event <= exceed && (next_run >= need);
      end
   end

   a_inside_restart: assert property (@(posedge pclk) disable iff (!presetn)
      enable && sample_valid && !exceed |=> !trip_event && run == '0)
      else $error("trip run not restarted on in-limit sample");

   a_count_gate: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(trip_event) |-> $past(next_run) >= $past(need))
      else $error("trip raised before deglitch count reached");

endmodule

`default_nettype wire

/* ocl_regs.sv */
// Operation
// - Upper trip limit is a 16-bit two's complement code.
// - Upper event when fast result is above the upper limit.
// - Upper limit 7fff switches upper detection off.
// - Lower trip limit is a 16-bit two's complement code, same scale.
// - Lower event when fast result is below the lower limit.
// - Lower limit 8000 switches lower detection off.
// - Lower limit sits at index c9, resets to 8000.
// - Spare bits are plain storage with no effect on behaviour.
// - Spare word at ca holds sixteen bits, resets to 5555.
// - Spare word at cb holds bits 10:4, resets to 0010.
// - Word cb bits 15:11 and 3:0 read zero.
// - Word cc holds bits 15:14, 10:8, 1:0; others read zero.
// - Upper limit sits at index c8, resets to 7fff.
// - Trip only after the set run of exceeding results; restart inside.
// - Comparator works only while enabled, independent of conversion start.
// - Fault output active on either event, level set by polarity.
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"

module ocl_regs #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fast filter result, same clock
   input wire logic [15:0] fast_result,
   input wire logic fast_result_valid,
   // Trip events and fault pin
   output ocl_pkg::ocl_trip_t trip_event,
   output logic overcurrent_fault_output,
   output logic fast_comparator_enable,
   // Spare contents for the map checksum
   output logic [15:0] spare_word_a,
   output logic [15:0] spare_word_b,
   output logic [15:0] spare_word_c,
   // Interrupt
   output logic irq
);

   ocl_pkg::ocl_cfg_t cfg;
   logic [15:0] upper_trip_limit;
   logic [15:0] lower_trip_limit;
   ocl_pkg::ocl_trip_t irq_status;
   ocl_pkg::ocl_trip_t irq_mask;
   ocl_pkg::ocl_trip_t trip_prev;
   ocl_pkg::ocl_trip_t trip_rise;
   ocl_pkg::ocl_trip_t next_status;
   ocl_pkg::ocl_trip_t exceed;

   logic setup;
   logic wr_en;
   logic mapped;
   logic [15:0] read_word;
   logic [15:0] wdata;
   logic [CNT_W-1:0] need;
   logic upper_armed;
   logic lower_armed;

   // Word decode, reused for every register
   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      return (a[11:10] == 2'b00) && (a[9:2] == idx);
   endfunction

   // Deglitch code to run length
   function automatic logic [CNT_W-1:0] run_len(input logic [4:0] code);
      logic [7:0] n;
      n = 8'h01;
      unique case (code) inside
         [5'h00:5'h07]: n = {3'h0, code} + 8'h01;
         [5'h08:5'h0f]: n = {2'h0, code, 1'b0} - 8'h06;
         5'h10: n = 8'h1c;
         5'h11: n = 8'h20;
         5'h12: n = 8'h28;
         5'h13: n = 8'h30;
         5'h14: n = 8'h38;
         5'h15: n = 8'h40;
         5'h16: n = 8'h48;
         5'h17: n = 8'h50;
         5'h18: n = 8'h58;
         5'h19: n = 8'h60;
         5'h1a: n = 8'h68;
         5'h1b: n = 8'h70;
         5'h1c: n = 8'h74;
         5'h1d: n = 8'h78;
         5'h1e: n = 8'h7c;
         5'h1f: n = 8'h80;
      endcase
      return CNT_W'(n);
   endfunction

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && pready;
   assign wdata = pwdata[15:0];
   assign need = run_len(cfg.num);
   // Switching a side off also drops a held event and its run
   assign upper_armed = cfg.enable && (upper_trip_limit != `OCL_UPPER_OFF);
   assign lower_armed = cfg.enable && (lower_trip_limit != `OCL_LOWER_OFF);

   // Bus answers

   always_comb begin
      read_word = 16'h0000;
      mapped = 1'b1;
      if (hit(paddr, `OCL_IDX_CFG)) begin
         read_word = {cfg, 8'h00};
      end else if (hit(paddr, `OCL_IDX_UPPER)) begin
         read_word = upper_trip_limit;
      end else if (hit(paddr, `OCL_IDX_LOWER)) begin
         read_word = lower_trip_limit;
      end else if (hit(paddr, `OCL_IDX_SPARE_A)) begin
         read_word = spare_word_a;
      end else if (hit(paddr, `OCL_IDX_SPARE_B)) begin
         read_word = spare_word_b;
      end else if (hit(paddr, `OCL_IDX_SPARE_C)) begin
         read_word = spare_word_c;
      end else if (hit(paddr, `OCL_IDX_IRQ_STAT)) begin
         read_word = {14'h0000, irq_status};
      end else if (hit(paddr, `OCL_IDX_IRQ_MASK)) begin
         read_word = {14'h0000, irq_mask};
      end else begin
         mapped = 1'b0;
      end
   end

   // One wait-free access phase; answer prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
         end
      end
   end

   // Register file

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_trip_limit <= `OCL_RST_UPPER;
         lower_trip_limit <= `OCL_RST_LOWER;
      end else if (wr_en) begin
         if (hit(paddr, `OCL_IDX_UPPER)) begin
            upper_trip_limit <= wdata;
         end
         if (hit(paddr, `OCL_IDX_LOWER)) begin
            lower_trip_limit <= wdata;
         end
      end
   end

   // Spares steer nothing; only the bus read path and the checksum read them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spare_word_a <= `OCL_RST_SPARE_A;
         spare_word_b <= `OCL_RST_SPARE_B;
         spare_word_c <= `OCL_RST_SPARE_C;
      end else if (wr_en) begin
         if (hit(paddr, `OCL_IDX_SPARE_A)) begin
            spare_word_a <= wdata;
         end
         if (hit(paddr, `OCL_IDX_SPARE_B)) begin
            spare_word_b <= wdata & `OCL_MASK_SPARE_B;
         end
         if (hit(paddr, `OCL_IDX_SPARE_C)) begin
            spare_word_c <= wdata & `OCL_MASK_SPARE_C;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= ocl_pkg::ocl_cfg_t'(`OCL_RST_CFG >> `OCL_CFG_LSB);
      end else if (wr_en && hit(paddr, `OCL_IDX_CFG)) begin
         cfg <= ocl_pkg::ocl_cfg_t'(wdata[15:`OCL_CFG_LSB]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_comparator_enable <= 1'b0;
      end else begin
         fast_comparator_enable <= cfg.enable;
      end
   end

   // Limit comparison

   // Signed on both sides; equality stays inside the window
   always_comb begin
      exceed.upper = (upper_trip_limit != `OCL_UPPER_OFF)
         && ($signed(fast_result) > $signed(upper_trip_limit));
      exceed.lower = (lower_trip_limit != `OCL_LOWER_OFF)
         && ($signed(fast_result) < $signed(lower_trip_limit));
   end

   ocl_trip_filter #(
      .CNT_W(CNT_W)
   ) u_upper (
      .pclk(pclk),
      .presetn(presetn),
      .enable(upper_armed),
      .sample_valid(fast_result_valid),
      .exceed(exceed.upper),
      .need(need),
      .trip_event(trip_event.upper)
   );

   ocl_trip_filter #(
      .CNT_W(CNT_W)
   ) u_lower (
      .pclk(pclk),
      .presetn(presetn),
      .enable(lower_armed),
      .sample_valid(fast_result_valid),
      .exceed(exceed.lower),
      .need(need),
      .trip_event(trip_event.lower)
   );

   // Fault pin idles high because polarity resets to active low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overcurrent_fault_output <= 1'b1;
      end else begin
         overcurrent_fault_output <= cfg.polarity ? (|trip_event) : !(|trip_event);
      end
   end

   // Interrupts

   assign trip_rise = trip_event & ~trip_prev;

   // A new trip in the clearing cycle survives the clear
   always_comb begin
      next_status = irq_status;
      if (wr_en && hit(paddr, `OCL_IDX_IRQ_STAT)) begin
         next_status = irq_status & ~ocl_pkg::ocl_trip_t'(wdata[1:0]);
      end
      next_status = next_status | trip_rise;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_prev <= '0;
         irq_status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         trip_prev <= trip_event;
         irq_status <= next_status;
         irq <= |(next_status & irq_mask);
         if (wr_en && hit(paddr, `OCL_IDX_IRQ_MASK)) begin
            irq_mask <= ocl_pkg::ocl_trip_t'(wdata[1:0]);
         end
      end
   end

   // Checks

   a_upper_off: assert property (@(posedge pclk) disable iff (!presetn)
      (upper_trip_limit == `OCL_UPPER_OFF)[*2] |-> !trip_event.upper)
      else $error("upper trip while upper limit is off");

   a_lower_off: assert property (@(posedge pclk) disable iff (!presetn)
      (lower_trip_limit == `OCL_LOWER_OFF)[*2] |-> !trip_event.lower)
      else $error("lower trip while lower limit is off");

   a_upper_trip: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.enable && fast_result_valid && need == CNT_W'(1)
      && upper_trip_limit != `OCL_UPPER_OFF
      && $signed(fast_result) > $signed(upper_trip_limit)
      |=> trip_event.upper)
      else $error("upper trip missing on single-sample run");

   a_lower_trip: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.enable && fast_result_valid && need == CNT_W'(1)
      && lower_trip_limit != `OCL_LOWER_OFF
      && $signed(fast_result) < $signed(lower_trip_limit)
      |=> trip_event.lower)
      else $error("lower trip missing on single-sample run");

   a_equal_no_trip: assert property (@(posedge pclk) disable iff (!presetn)
      fast_result_valid && fast_result == upper_trip_limit
      |=> !trip_event.upper)
      else $error("result equal to upper limit tripped");

   a_lower_equal: assert property (@(posedge pclk) disable iff (!presetn)
      fast_result_valid && fast_result == lower_trip_limit
      |=> !trip_event.lower)
      else $error("result equal to lower limit tripped");

   a_disable_clears: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg.enable |=> trip_event == '0)
      else $error("trip event while comparator disabled");

   a_fault_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 1'b1 |-> overcurrent_fault_output
         == ($past(cfg.polarity) ? $past(|trip_event) : !$past(|trip_event)))
      else $error("fault output level wrong");

   a_cb_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit(paddr, `OCL_IDX_SPARE_B)
      |=> prdata[31:11] == 21'h000000 && prdata[3:0] == 4'h0)
      else $error("reserved bits of spare word b read nonzero");

   a_spare_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && hit(paddr, `OCL_IDX_SPARE_C)
      |=> spare_word_c == ($past(pwdata[15:0]) & `OCL_MASK_SPARE_C))
      else $error("spare word c write not stored as masked");

   a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      trip_rise.upper |=> irq_status.upper)
      else $error("upper trip did not set status");

   c_upper_trip: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(trip_event.upper));

   c_lower_trip: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(trip_event.lower));

   c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn)
      trip_rise.upper && wr_en && hit(paddr, `OCL_IDX_IRQ_STAT));

   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule

`default_nettype wire

/* ocl_host.sv */
`timescale 1ns/1ps
`default_nettype none

module ocl_host (
   // Clock
   input wire logic pclk,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic timed_out;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      timed_out = 1'b0;
   end

   // Call right after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d,
         output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) timed_out = 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge keeps the next setup out of this time step
      @(posedge pclk);
   endtask
endmodule

`default_nettype wire

/* overcurrent_limit_and_spare_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"

module overcurrent_limit_and_spare_regs_test;
   typedef struct {
      logic [7:0] idx;
      logic [15:0] rst;
      logic [15:0] wd;
      logic [15:0] exp;
   } ocl_row_t;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] fast_result, spare_word_a, spare_word_b, spare_word_c;
   logic fast_result_valid, overcurrent_fault_output, fast_comparator_enable, irq, e;
   ocl_pkg::ocl_trip_t trip_event;
   ocl_row_t rows [6];
   int n_errors, n_tests;

   ocl_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fast_result(fast_result), .fast_result_valid(fast_result_valid),
      .trip_event(trip_event), .overcurrent_fault_output(overcurrent_fault_output),
      .fast_comparator_enable(fast_comparator_enable), .spare_word_a(spare_word_a),
      .spare_word_b(spare_word_b), .spare_word_c(spare_word_c), .irq(irq));

   ocl_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic end_of_test();
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [7:0] idx, input logic [15:0] d);
      host.xfer(wr, idx, d, r, e);
      if (host.timed_out) begin
         n_errors++;
         end_of_test();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      acc(1'b1, idx, d);
      chk({31'h0, e}, 32'h0);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
      acc(1'b0, idx, 16'h0000);
      chk(r, {16'h0000, exp});
   endtask

   // Valid every cycle for n samples, then time for event, pin and irq to settle
   task automatic feed(input logic [15:0] v, input int n);
      fast_result <= v;
      fast_result_valid <= 1'b1;
      repeat (n) @(posedge pclk);
      fast_result_valid <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end

   initial begin
      presetn = 1'b0;
      fast_result = 16'h0000;
      fast_result_valid = 1'b0;
      n_errors = 0;
      n_tests = 0;
      rows = '{'{`OCL_IDX_UPPER, 16'h7fff, 16'h8001, 16'h8001},
         '{`OCL_IDX_LOWER, 16'h8000, 16'h7ffe, 16'h7ffe},
         '{`OCL_IDX_SPARE_A, 16'h5555, 16'haaaa, 16'haaaa},
         '{`OCL_IDX_SPARE_B, 16'h0010, 16'hffff, 16'h07f0},
         '{`OCL_IDX_SPARE_C, 16'h0000, 16'hffff, 16'hc703},
         '{`OCL_IDX_CFG, 16'h0000, 16'h7fff, 16'h7f00}};
      repeat (8) @(posedge pclk);
      chk({31'h0, overcurrent_fault_output}, 32'h1);
      chk({16'h0, spare_word_b}, 32'h0010);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) rd(rows[i].idx, rows[i].rst);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         rd(rows[i].idx, rows[i].exp);
      end
      chk({spare_word_a, spare_word_c}, 32'haaaa_c703);
      acc(1'b0, 8'hc0, 16'h0000);
      chk({e, r[30:0]}, 32'h8000_0000);
      wr(`OCL_IDX_UPPER, 16'h0100);
      wr(`OCL_IDX_LOWER, 16'hff00);
      wr(`OCL_IDX_IRQ_MASK, 16'h0003);
      // Enabled, active high, run of three
      wr(`OCL_IDX_CFG, 16'hc200);
      @(posedge pclk);
      chk({31'h0, fast_comparator_enable}, 32'h1);
      feed(16'h0100, 5);
      chk({30'h0, trip_event}, 32'h0);
      feed(16'h0101, 2);
      feed(16'h0000, 1);
      feed(16'h0101, 2);
      chk({30'h0, trip_event}, 32'h0);
      feed(16'h0101, 1);
      chk({30'h0, trip_event}, 32'h1);
      chk({30'h0, overcurrent_fault_output, irq}, 32'h3);
      feed(16'h0000, 1);
      chk({30'h0, trip_event}, 32'h0);
      chk({31'h0, overcurrent_fault_output}, 32'h0);
      rd(`OCL_IDX_IRQ_STAT, 16'h0001);
      wr(`OCL_IDX_IRQ_STAT, 16'h0001);
      rd(`OCL_IDX_IRQ_STAT, 16'h0000);
      chk({31'h0, irq}, 32'h0);
      wr(`OCL_IDX_IRQ_MASK, 16'h0001);
      feed(16'hff00, 4);
      chk({30'h0, trip_event}, 32'h0);
      feed(16'h8001, 3);
      chk({30'h0, trip_event}, 32'h2);
      chk({31'h0, irq}, 32'h0);
      rd(`OCL_IDX_IRQ_STAT, 16'h0002);
      wr(`OCL_IDX_LOWER, 16'h8000);
      feed(16'h8000, 4);
      chk({30'h0, trip_event}, 32'h0);
      wr(`OCL_IDX_UPPER, 16'h7fff);
      feed(16'h7fff, 4);
      chk({30'h0, trip_event}, 32'h0);
      wr(`OCL_IDX_UPPER, 16'h0100);
      wr(`OCL_IDX_CFG, 16'h4200);
      feed(16'h7000, 4);
      chk({29'h0, trip_event, fast_comparator_enable}, 32'h0);
      // Active low pin
      wr(`OCL_IDX_CFG, 16'h8200);
      feed(16'h7000, 3);
      chk({30'h0, trip_event}, 32'h1);
      chk({31'h0, overcurrent_fault_output}, 32'h0);
      // Single-sample run on both sides
      wr(`OCL_IDX_LOWER, 16'hff00);
      wr(`OCL_IDX_CFG, 16'h8000);
      feed(16'h8001, 1);
      chk({30'h0, trip_event}, 32'h2);
      feed(16'h0101, 1);
      chk({30'h0, trip_event}, 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      chk({30'h0, trip_event}, 32'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({29'h0, overcurrent_fault_output, irq, fast_comparator_enable}, 32'h4);
      chk({spare_word_a, spare_word_b}, 32'h5555_0010);
      rd(`OCL_IDX_UPPER, 16'h7fff);
      end_of_test();
   end
endmodule

`default_nettype wire
